/* File: swg_filter.sv */
`timescale 1ns/1ps
// Two-flop synchroniser followed by a stability filter: the output only
// follows the input once it has held one level for WIDTH cycles
module swg_filter #(
    parameter int unsigned WIDTH = 11,
    parameter logic        INIT  = 1'b1
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level_out
);

    typedef struct packed {
        logic                           s1;    // First sync stage
        logic                           s2;    // Second sync stage
        logic [swg_pkg::FILT_W-1:0]     cnt;   // Stable-level counter
        logic                           lvl;   // Filtered level
    } swg_filt_s;

    swg_filt_s st_q;  // Registered state
    swg_filt_s st_d;  // Next state

    // Filter next-state logic; s1 feeds only s2
    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        if (st_q.s2 == st_q.lvl)
        begin
            // Level agrees, restart the count
            st_d.cnt = '0;
        end
        else if (st_q.cnt == swg_pkg::FILT_W'(WIDTH - 1))
        begin
            // Held long enough, accept the new level
            st_d.lvl = st_q.s2;
            st_d.cnt = '0;
        end
        else
        begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '{s1: INIT, s2: INIT, cnt: '0, lvl: INIT};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;

endmodule

/* File: swg_master_model.sv */
`timescale 1ns/1ps
// Bus master and board wiring: serial clock within frames, pins with pulls
module swg_master_model (
    input  wire logic frame_en,         // Master runs a frame
    input  wire logic master_sda,       // Master data level, 0 pulls low
    input  wire logic ext_pull_low,     // Agent pulls low-active pin low
    input  wire logic ext_drive_high,   // Agent drives high-active pin high
    input  wire logic sda_out,
    input  wire logic sda_oe_n,
    input  wire logic reset_n_pin_out,
    input  wire logic reset_n_pin_oe_n,
    input  wire logic reset_pin_out,
    input  wire logic reset_pin_oe_n,
    output logic      scl_in,
    output logic      sda_in,
    output logic      reset_n_pin_in,
    output logic      reset_pin_in
);
    logic scl_q;                        // Master clock, 125 ns period
    initial scl_q = 1'b1;
    // Toggles inside frames only, stands high (pulled up) between them
    always
    begin
        #62.5;
        scl_q = frame_en ? ~scl_q : 1'b1;
    end
    assign scl_in = scl_q;
    // Wired-AND data line with pull-up
    assign sda_in = master_sda & (sda_oe_n | sda_out);
    // Low-active pin with pull-up, high-active pin with pull-down
    assign reset_n_pin_in = ~ext_pull_low & (reset_n_pin_oe_n | reset_n_pin_out);
    assign reset_pin_in = ext_drive_high | (~reset_pin_oe_n & reset_pin_out);
endmodule

/* File: swg_pkg.sv */
// Shared constants of the supervisor, watchdog and write guard
package swg_pkg;

    // Core clock period in picoseconds (100 MHz)
    localparam int unsigned CLK_PERIOD_PS = 10000;

    // Time base tick in microseconds, all long timeouts count these
    localparam int unsigned TICK_US       = 100;
    localparam int unsigned TICK_CYCLES   = (TICK_US * 1000000) / CLK_PERIOD_PS;

    // Watchdog period, 1.6 s, in milliseconds
    localparam int unsigned WATCHDOG_PERIOD_MS      = 1600;
    localparam int unsigned WATCHDOG_PERIOD_TICKS   = (WATCHDOG_PERIOD_MS * 1000) / TICK_US;

    // Power-up hold window 130..270 ms; nominal 200 ms sits inside it
    localparam int unsigned POWERUP_HOLD_MIN_MS     = 130;
    localparam int unsigned POWERUP_HOLD_MAX_MS     = 270;
    localparam int unsigned POWERUP_HOLD_TIME_TICKS =
        ((POWERUP_HOLD_MIN_MS + POWERUP_HOLD_MAX_MS) / 2 * 1000) / TICK_US;

    // Program cycle time, at most 10 ms (longest time, rounded down)
    localparam int unsigned PROGRAM_CYCLE_TIME_MS    = 10;
    localparam int unsigned PROGRAM_CYCLE_TIME_TICKS = (PROGRAM_CYCLE_TIME_MS * 1000) / TICK_US;

    // Glitch reject width on reset pins, 100 ns; accept after this plus one cycle
    localparam int unsigned GLITCH_REJECT_WIDTH_NS = 100;
    localparam int unsigned GLITCH_CYCLES =
        (GLITCH_REJECT_WIDTH_NS * 1000) / CLK_PERIOD_PS + 1;

    // Noise spike suppression on serial lines, 200 ns
    localparam int unsigned SPIKE_WIDTH_NS = 200;
    localparam int unsigned SPIKE_CYCLES   = (SPIKE_WIDTH_NS * 1000) / CLK_PERIOD_PS + 1;

    // Threshold to reset delay, 5 us, in cycles (longest, rounded down)
    localparam int unsigned THRESHOLD_TO_RESET_DELAY_NS     = 5000;
    localparam int unsigned THRESHOLD_TO_RESET_DELAY_CYCLES =
        (THRESHOLD_TO_RESET_DELAY_NS * 1000) / CLK_PERIOD_PS;

    // Counter widths
    localparam int unsigned TICK_W  = 14;
    localparam int unsigned SLOW_W  = 15;
    localparam int unsigned FILT_W  = 5;

    // Supervisor states
    typedef enum logic [1:0] {
        SWG_HOLD,
        SWG_RUN
    } swg_state_e;

endpackage

/* File: swg_top.sv */
`timescale 1ns/1ps
// Functional notes
// (R01) Timeout after 1.6 s without kick edges
// (R02) Hold resets 130 to 270 ms after power-up
// (R03) Externally forced reset pins start a reset
// (R04) Reset pins are open-drain, pull only
// (R05) Reset pin pulses up to 100 ns ignored
// (R06) Reset follows supply crossing within 5 us
// (R07) Write-protect high refuses all writes
// (R08) Program cycle starts at stop, ends by 10 ms
// (R09) Serial slave disabled during program cycle
// (R10) Master waits 1 ms after supply stable
// (R11) Serial inputs suppress spikes up to 200 ns
// (R12) Serial data pin only pulls low
// (R13) Any kick edge clears watchdog count
// (R14) Watchdog cleared while reset is asserted
// (R15) Manual reset inputs are edge triggered
// (R16) No memory access or acknowledge during reset
// (R17) Power-good synchronised, timing from internal tick
// (R18) Watchdog timeout runs full reset hold sequence
module swg_top #(
    // Core cycles per time base tick; a shorter ratio lets a bench reach the long timeouts
    parameter int unsigned TICK_DIV = swg_pkg::TICK_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic power_good_in,       // Supply above trip level, asynchronous
    input  wire logic watchdog_kick_in,    // Kick pin, asynchronous
    input  wire logic write_protect_in,    // Write-protect pin, asynchronous
    input  wire logic reset_n_pin_in,      // Active-low reset pin level
    output logic      reset_n_pin_out,     // Always zero when driven
    output logic      reset_n_pin_oe_n,    // Low while pulling the pin low
    input  wire logic reset_pin_in,        // Active-high reset pin level
    output logic      reset_pin_out,       // Always one when driven
    output logic      reset_pin_oe_n,      // Low while driving the pin high
    input  wire logic scl_in,              // Serial clock pin
    input  wire logic sda_in,              // Serial data pin level
    output logic      sda_out,             // Always zero when driven
    output logic      sda_oe_n,            // Low while pulling data low
    input  wire logic slave_ack_req,       // Slave core wants to acknowledge
    input  wire logic slave_write_stop,    // Valid stop ending a write sequence
    output logic      slave_enable,        // Slave core may respond
    output logic      write_allowed,       // Array writes permitted
    output logic      program_busy,        // Internal program cycle running
    output logic      scl_filtered,        // Spike-free serial clock
    output logic      sda_filtered,        // Spike-free serial data
    output logic      reset_active         // Supervisor holds reset
);

    typedef struct packed {
        logic [1:0]                     pg;       // Power-good two-flop sync
        logic [2:0]                     kick;     // Kick sync plus previous value
        logic [1:0]                     wp;       // Write-protect sync
        logic                           rn_prev;  // Previous filtered low-active pin
        logic                           rh_prev;  // Previous filtered high-active pin
        logic [swg_pkg::TICK_W-1:0]     tick_cnt; // Time base divider
        logic [swg_pkg::SLOW_W-1:0]     wd_cnt;   // Watchdog tick count
        logic [swg_pkg::SLOW_W-1:0]     hold_cnt; // Reset hold tick count
        logic [swg_pkg::SLOW_W-1:0]     prog_cnt; // Program cycle tick count
        logic                           prog;     // Program cycle running
        swg_pkg::swg_state_e            state;    // Supervisor state
    } swg_top_s;

    swg_top_s st_q;   // Registered state
    swg_top_s st_d;   // Next state

    logic rn_filt;    // Filtered active-low reset pin
    logic rh_filt;    // Filtered active-high reset pin
    logic tick;       // Time base enable pulse
    logic kick_edge;  // Any kick transition
    logic manual_trig;// Manual reset edge seen
    logic wd_expire;  // Watchdog timeout
    logic pg_ok;      // Synchronised power-good

    // Reset pin glitch filters [R05]
    swg_filter #(.WIDTH(swg_pkg::GLITCH_CYCLES), .INIT(1'b1)) u_rn_filt (
        .core_clk  (core_clk),
        .rst       (rst),
        .pin_in    (reset_n_pin_in),
        .level_out (rn_filt)
    );
    swg_filter #(.WIDTH(swg_pkg::GLITCH_CYCLES), .INIT(1'b0)) u_rh_filt (
        .core_clk  (core_clk),
        .rst       (rst),
        .pin_in    (reset_pin_in),
        .level_out (rh_filt)
    );

    // Serial line spike filters [R11]
    swg_filter #(.WIDTH(swg_pkg::SPIKE_CYCLES), .INIT(1'b1)) u_scl_filt (
        .core_clk  (core_clk),
        .rst       (rst),
        .pin_in    (scl_in),
        .level_out (scl_filtered)
    );
    swg_filter #(.WIDTH(swg_pkg::SPIKE_CYCLES), .INIT(1'b1)) u_sda_filt (
        .core_clk  (core_clk),
        .rst       (rst),
        .pin_in    (sda_in),
        .level_out (sda_filtered)
    );

    // Derived conditions
    assign pg_ok       = st_q.pg[1];                                   // [R17]
    assign tick        = (st_q.tick_cnt == swg_pkg::TICK_W'(TICK_DIV - 1));          // [R17]
    assign kick_edge   = st_q.kick[1] ^ st_q.kick[2];                  // [R13]
    assign manual_trig = (st_q.rn_prev & ~rn_filt) | (~st_q.rh_prev & rh_filt); // [R15]
    assign wd_expire   = tick && (st_q.wd_cnt == swg_pkg::SLOW_W'(swg_pkg::WATCHDOG_PERIOD_TICKS - 1)); // [R01]

    // Next-state logic
    always_comb
    begin
        st_d         = st_q;
        // Synchronisers; stage 0 read only by stage 1
        st_d.pg      = {st_q.pg[0], power_good_in};
        st_d.kick    = {st_q.kick[1], st_q.kick[0], watchdog_kick_in};
        st_d.wp      = {st_q.wp[0], write_protect_in};
        st_d.rn_prev = rn_filt;
        st_d.rh_prev = rh_filt;
        // Free running time base
        st_d.tick_cnt = tick ? '0 : st_q.tick_cnt + 1'b1;              // [R17]

        unique case (st_q.state)
            swg_pkg::SWG_HOLD:
            begin
                st_d.wd_cnt = '0;                                      // [R14]
                if (!pg_ok || manual_trig)
                begin
                    // Supply low or new manual edge: restart hold [R03] [R06]
                    // Pin levels are not read here, our own drive forces them
                    st_d.hold_cnt = '0;
                end
                else if (tick)
                begin
                    if (st_q.hold_cnt == swg_pkg::SLOW_W'(swg_pkg::POWERUP_HOLD_TIME_TICKS - 1))
                    begin
                        // Hold timeout expired, release [R02]
                        st_d.hold_cnt = '0;
                        st_d.state    = swg_pkg::SWG_RUN;
                    end
                    else
                    begin
                        st_d.hold_cnt = st_q.hold_cnt + 1'b1;
                    end
                end
            end
            swg_pkg::SWG_RUN:
            begin
                if (!pg_ok || manual_trig || wd_expire)
                begin
                    // Brownout, manual edge or watchdog: full hold [R03] [R06] [R15] [R18]
                    st_d.state    = swg_pkg::SWG_HOLD;
                    st_d.hold_cnt = '0;
                    st_d.wd_cnt   = '0;
                end
                else if (kick_edge)
                begin
                    st_d.wd_cnt = '0;                                  // [R13]
                end
                else if (tick)
                begin
                    st_d.wd_cnt = st_q.wd_cnt + 1'b1;                  // [R01]
                end
            end
            default:
            begin
                // Illegal state code falls back to holding reset
                st_d.state = swg_pkg::SWG_HOLD;
            end
        endcase

        // Program cycle timer
        if (st_q.prog)
        begin
            if (tick)
            begin
                if (st_q.prog_cnt == swg_pkg::SLOW_W'(swg_pkg::PROGRAM_CYCLE_TIME_TICKS - 1))
                begin
                    st_d.prog = 1'b0;                                  // [R08]
                end
                st_d.prog_cnt = st_q.prog_cnt + 1'b1;
            end
        end
        else if (slave_write_stop && write_allowed)
        begin
            // Stop of an accepted write starts programming [R08]
            st_d.prog     = 1'b1;
            st_d.prog_cnt = '0;
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '{pg: '0, kick: '0, wp: '0, rn_prev: 1'b1, rh_prev: 1'b0,
                      tick_cnt: '0, wd_cnt: '0, hold_cnt: '0, prog_cnt: '0,
                      prog: 1'b0, state: swg_pkg::SWG_HOLD};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Reset pins: drive only the asserted level [R04]
    assign reset_active     = (st_q.state == swg_pkg::SWG_HOLD);
    assign reset_n_pin_out  = 1'b0;
    assign reset_n_pin_oe_n = ~reset_active;                           // [R04]
    assign reset_pin_out    = 1'b1;
    assign reset_pin_oe_n   = ~reset_active;                           // [R04]

    // Slave gating during reset or programming [R09] [R16]
    assign program_busy  = st_q.prog;
    assign slave_enable  = ~reset_active & ~st_q.prog;                 // [R09] [R16]
    assign write_allowed = slave_enable & ~st_q.wp[1];                 // [R07]

    // Serial data only ever pulled low [R12]
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~(slave_ack_req & slave_enable);                 // [R12] [R16]

endmodule

/* File: swg_top_asserts.sv */
`timescale 1ns/1ps
// Port-level checks of the supervisor top
module swg_top_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic power_good_in,
    input wire logic write_protect_in,
    input wire logic slave_ack_req,
    input wire logic reset_n_pin_out,
    input wire logic reset_n_pin_oe_n,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic slave_write_stop,
    input wire logic slave_enable,
    input wire logic write_allowed,
    input wire logic program_busy,
    input wire logic reset_active
);
    // One clock domain for all checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_pin_drive_const: assert property (!reset_n_pin_out && reset_pin_out)
        else $error("reset pin drive level wrong");
    a_sda_pull_only: assert property (!sda_out)
        else $error("data pin driven high");
    a_reset_drives_pins: assert property (reset_active |-> !reset_n_pin_oe_n && !reset_pin_oe_n)
        else $error("reset pins released while holding");
    a_no_ack_reset: assert property (reset_active |-> sda_oe_n && !slave_enable)
        else $error("acknowledge during reset");
    a_busy_no_ack: assert property (program_busy |-> sda_oe_n && !slave_enable)
        else $error("slave active while programming");
    a_write_gate: assert property (write_allowed |-> slave_enable && !program_busy)
        else $error("write allowed while blocked");
    a_brownout_fast: assert property ($fell(power_good_in) ##1 !power_good_in [*3] |-> ##[0:496] reset_active)
        else $error("reset late after supply drop");
    a_program_start: assert property (slave_write_stop && write_allowed |=> program_busy)
        else $error("program cycle not started");
    a_busy_cause: assert property ($rose(program_busy) |-> $past(slave_write_stop) && $past(write_allowed))
        else $error("program cycle without accepted stop");
    a_wp_blocks: assert property (write_protect_in [*3] |-> !write_allowed)
        else $error("write allowed while protected");
    a_ack_needs_req: assert property (!sda_oe_n |-> slave_ack_req)
        else $error("data pulled low without request");
endmodule
bind swg_top swg_top_checker chk_u (.core_clk(core_clk), .rst(rst), .power_good_in(power_good_in),
    .write_protect_in(write_protect_in), .slave_ack_req(slave_ack_req),
    .reset_n_pin_out(reset_n_pin_out), .reset_n_pin_oe_n(reset_n_pin_oe_n), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .slave_write_stop(slave_write_stop), .slave_enable(slave_enable), .write_allowed(write_allowed),
    .program_busy(program_busy), .reset_active(reset_active));

/* File: swg_top_test.sv */
`timescale 1ns/1ps
// Self-checking bench; the long hold keeps the serial filter and access tests inside the reset window
module swg_top_test;
    logic core_clk = 0, rst = 1, power_good_in = 0, watchdog_kick_in = 0, write_protect_in = 0;
    logic slave_ack_req = 0, slave_write_stop = 0, frame_en = 0, master_sda = 1, ext_low = 0, ext_high = 0;
    logic scl_in, sda_in, rn_in, rn_out, rn_oe_n, rp_in, rp_out, rp_oe_n, sda_out, sda_oe_n;
    logic slave_enable, write_allowed, program_busy, scl_f, sda_f, reset_active;
    int err_count = 0, check_count = 0, cycles = 0, i, w, t0;
    logic dip;                      // Filtered data dipped low inside a window
    localparam int TB_TICK = 2;     // Shortened time base so the long timeouts fit the run
    always #5 core_clk = ~core_clk;
    swg_top #(.TICK_DIV(TB_TICK)) dut_u (.core_clk(core_clk), .rst(rst), .power_good_in(power_good_in),
        .watchdog_kick_in(watchdog_kick_in), .write_protect_in(write_protect_in),
        .reset_n_pin_in(rn_in), .reset_n_pin_out(rn_out), .reset_n_pin_oe_n(rn_oe_n),
        .reset_pin_in(rp_in), .reset_pin_out(rp_out), .reset_pin_oe_n(rp_oe_n), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .slave_ack_req(slave_ack_req),
        .slave_write_stop(slave_write_stop), .slave_enable(slave_enable), .write_allowed(write_allowed),
        .program_busy(program_busy), .scl_filtered(scl_f), .sda_filtered(sda_f), .reset_active(reset_active));
    swg_master_model mst_u (.frame_en(frame_en), .master_sda(master_sda), .ext_pull_low(ext_low),
        .ext_drive_high(ext_high), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reset_n_pin_out(rn_out),
        .reset_n_pin_oe_n(rn_oe_n), .reset_pin_out(rp_out), .reset_pin_oe_n(rp_oe_n), .scl_in(scl_in),
        .sda_in(sda_in), .reset_n_pin_in(rn_in), .reset_pin_in(rp_in));
    // Cuts a hang short
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            err_count++;
            give_verdict();
        end
    end
    // Compares one output bit
    task check(input logic got, input logic exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    // Lets n edges pass, then drives just after the last
    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Filter output after a pulse of the given width away from idle
    function automatic logic filt_expect(input int width, input logic idle);
        return (width * 10 <= swg_pkg::SPIKE_WIDTH_NS) ? idle : ~idle;
    endfunction
    // Bench cycles for a time given in milliseconds, on the shortened time base
    function automatic int ms_cycles(input int unsigned ms);
        return int'((ms * 1000) / swg_pkg::TICK_US) * TB_TICK;
    endfunction
    // Waits for the hold to end, checks its length from t0_in and the released pins
    task wait_release(input int t0_in);
        int n;
        while (reset_active && cycles - t0_in < 6000)
        begin
            step(1);
        end
        n = cycles - t0_in;
        check(n >= ms_cycles(swg_pkg::POWERUP_HOLD_MIN_MS), 1'b1, "hold too short");
        check(n <= ms_cycles(swg_pkg::POWERUP_HOLD_MAX_MS), 1'b1, "hold too long");
        step(20);
        check(rn_in & ~rp_in & rn_oe_n & rp_oe_n, 1'b1, "pins not released");
    endtask
    // Prints counts and the verdict, then ends the run
    task give_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(32'h4c04de3d));
        step(5);
        rst = 0;
        step(3);
        check(reset_active, 1'b1, "no reset after start");
        check(rn_oe_n | rp_oe_n, 1'b0, "pins not driven");
        check(rn_in | ~rp_in, 1'b0, "pin level wrong");
        power_good_in = 1;
        t0 = cycles;
        step(300);
        check(reset_active, 1'b1, "released too early");
        $display("test reset hold done");
        frame_en = 1;
        for (i = 0; i < 16; i++)
        begin
            w = (i < 2) ? 20 + i : $urandom_range(1, 30);
            master_sda = 0;
            step(w);
            master_sda = 1;
            dip = 1'b0;
            repeat (30)
            begin
                step(1);
                dip = dip | ~sda_f;
            end
            check(~dip, filt_expect(w, 1'b1), "data spike filter wrong");
            check(scl_f, 1'b1, "clock spike passed");
        end
        frame_en = 0;
        master_sda = 0;
        step(40);
        check(sda_f, filt_expect(40, 1'b1), "data level not followed");
        master_sda = 1;
        step(40);
        $display("test serial filter done");
        for (i = 0; i < 20; i++)
        begin
            slave_ack_req = 1'($urandom);
            write_protect_in = 1'($urandom);
            watchdog_kick_in = ~watchdog_kick_in;
            slave_write_stop = 1;
            step(1);
            slave_write_stop = 0;
            step(1);
            check(sda_oe_n, 1'b1, "acknowledge in reset");
            check(program_busy | write_allowed, 1'b0, "write in reset");
        end
        $display("test access in reset done");
        wait_release(t0);
        $display("test power-up release done");
        // First acknowledged accesses come after the hold, far past the settling wait
        for (i = 0; i < 4; i++)
        begin
            write_protect_in = (i == 0) ? 1'b0 : 1'($urandom);
            slave_ack_req = 1;
            step(3);
            check(write_allowed, ~write_protect_in, "write gate wrong");
            check(sda_oe_n, 1'b0, "no acknowledge when enabled");
            slave_write_stop = 1;
            step(1);
            slave_write_stop = 0;
            check(program_busy, ~write_protect_in, "program start wrong");
            check(sda_oe_n, ~write_protect_in, "acknowledge while programming");
            check(slave_enable, write_protect_in, "slave enabled while programming");
            t0 = cycles;
            while (program_busy && cycles - t0 < 400)
            begin
                step(1);
            end
            check(cycles - t0 <= ms_cycles(swg_pkg::PROGRAM_CYCLE_TIME_MS), 1'b1, "program cycle too long");
        end
        slave_ack_req = 0;
        $display("test program cycle done");
        for (i = 0; i < 4; i++)
        begin
            w = (i < 2) ? 10 : $urandom_range(1, 10);
            ext_low = (i % 2 == 0);
            ext_high = (i % 2 == 1);
            step(w);
            ext_low = 0;
            ext_high = 0;
            step(30);
            check(reset_active, 1'b0, "reset pin glitch accepted");
        end
        $display("test pin glitch done");
        for (i = 0; i < 2; i++)
        begin
            ext_low = (i == 0);
            ext_high = (i == 1);
            t0 = cycles;
            step(20);
            ext_low = 0;
            ext_high = 0;
            check(reset_active, 1'b1, "forced pin lost reset");
            wait_release(t0);
        end
        $display("test manual reset done");
        power_good_in = 0;
        t0 = cycles;
        while (!reset_active && cycles - t0 < 600)
        begin
            step(1);
        end
        check(cycles - t0 <= swg_pkg::THRESHOLD_TO_RESET_DELAY_CYCLES, 1'b1, "reset late after drop");
        step(10);
        check(reset_active, 1'b1, "no reset on supply drop");
        power_good_in = 1;
        wait_release(cycles);
        $display("test brownout done");
        w = ms_cycles(swg_pkg::WATCHDOG_PERIOD_MS);
        step(w / 2);
        watchdog_kick_in = ~watchdog_kick_in;
        t0 = cycles;
        step(w * 5 / 8);
        check(reset_active, 1'b0, "kick edge did not clear watchdog");
        while (!reset_active && cycles - t0 < w + 100)
        begin
            step(1);
        end
        check(cycles - t0 >= w, 1'b1, "watchdog expired early");
        check(cycles - t0 <= w + 8, 1'b1, "watchdog expired late");
        wait_release(cycles);
        $display("test watchdog done");
        give_verdict();
    end
endmodule
